/* File: shared/vft_regs.svh */
// Constants for the frame trigger and tracking return block
`ifndef VFT_REGS_SVH
`define VFT_REGS_SVH

`define VFT_TARGETS 8
`define VFT_COORD_W 16
`define VFT_FRAME_W 16
`define VFT_STAMP_W 32
`define VFT_LOST_W 16
`define VFT_FRAME_RST 16'h0000
`define VFT_STAMP_RST 32'h0000_0000
`define VFT_LOST_RST 16'h0000

`endif

/* File: shared/vft_pkg.sv */
// Types for the frame trigger and tracking return block
`include "vft_regs.svh"

package vft_pkg;

    typedef struct packed {
        logic [`VFT_COORD_W-1:0] x;
        logic [`VFT_COORD_W-1:0] y;
    } vft_pos_type;

    typedef vft_pos_type [`VFT_TARGETS-1:0] vft_pos_set_type;

    typedef struct packed {
        logic [`VFT_FRAME_W-1:0] frame;
        logic [`VFT_STAMP_W-1:0] stamp;
        logic [`VFT_TARGETS-1:0] mask;
        vft_pos_set_type pos;
    } vft_rec_type;

    typedef enum logic [1:0] {
        VFT_IDLE,
        VFT_ARMED,
        VFT_CAPTURE,
        VFT_TRACK
    } vft_state_type;

endpackage

/* File: core/vft_link.sv */
// Frame trigger handling, capture sequencing and tracking record return
// Functional notes
// - Each trigger accepted while armed: capture, append, track, prepare
// - Record returned on following trigger only
// - At most eight configured targets per record
// - Sent record also logged with session timestamp
// - Lost frame counter, cleared by command/reset
// - Close message closes files, block idles
`timescale 1ns/1ps
`default_nettype none
`include "vft_regs.svh"

module vft_link (
    input wire logic core_clk,                          // 20 MHz clock
    input wire logic nrst,                              // Async reset, active low
    input wire logic trig_pin,                          // Frame trigger from fiber
    input wire logic session_open,                      // Pulse: recording session begins
    input wire logic session_close,                     // Pulse: close message received
    input wire logic lost_clear,                        // Pulse: user clears lost count
    input wire logic [`VFT_TARGETS-1:0] target_enable,  // Configured target set
    input wire logic cam_done,                          // Pulse: camera image received
    input wire logic trk_done,                          // Pulse: tracking finished
    input wire logic [`VFT_TARGETS-1:0] trk_found,      // Targets found by tracker
    input wire vft_pkg::vft_pos_set_type trk_pos,       // Tracker positions
    input wire logic out_ready,                         // Link side accepts record
    output logic out_valid,                             // Record to controller valid
    output vft_pkg::vft_rec_type out_rec,               // Record to controller
    output logic cam_req,                               // Pulse: fetch one image
    output logic file_append,                           // Pulse: append image to file
    output logic trk_start,                             // Pulse: start tracking
    output logic files_close,                           // Pulse: close open files
    output logic log_valid,                             // Pulse: log record
    output vft_pkg::vft_rec_type log_rec,               // Record written to log
    output logic recording,                             // Session open
    output logic [`VFT_LOST_W-1:0] lost_count           // Lost frame count
);

    typedef struct packed {
        vft_pkg::vft_state_type st;
        logic trig_s1;
        logic trig_s2;
        logic trig_d;
        logic [`VFT_STAMP_W-1:0] stamp;
        logic [`VFT_FRAME_W-1:0] frame;
        logic [`VFT_LOST_W-1:0] lost;
        vft_pkg::vft_rec_type cur;
        vft_pkg::vft_rec_type held;
        logic held_v;
        vft_pkg::vft_rec_type head;
        logic head_v;
        vft_pkg::vft_rec_type tail;
        logic tail_v;
        logic cam_req;
        logic file_append;
        logic trk_start;
        logic files_close;
        logic log_valid;
        vft_pkg::vft_rec_type log_rec;
        logic rec;
    } vft_core_type;

    logic rst_meta_r;
    logic rst_sync_n_r;
    vft_core_type s_r;
    vft_core_type s_nxt;
    wire vft_pkg::vft_pos_set_type pos_kept;

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // Targets outside the configured set never leave the block
    for (genvar g = 0; g < `VFT_TARGETS; g++) begin : g_keep
        assign pos_kept[g] = target_enable[g] ? trk_pos[g] : '0;
    end

    always_comb begin
        logic trig_ev;
        logic pop;
        logic push;
        logic room;
        vft_pkg::vft_rec_type push_rec;
        trig_ev = 1'b0;
        pop = 1'b0;
        push = 1'b0;
        room = 1'b0;
        push_rec = s_r.held;
        s_nxt = s_r;
        s_nxt.cam_req = 1'b0;
        s_nxt.file_append = 1'b0;
        s_nxt.trk_start = 1'b0;
        s_nxt.files_close = 1'b0;
        s_nxt.log_valid = 1'b0;

        s_nxt.trig_s1 = trig_pin;
        s_nxt.trig_s2 = s_r.trig_s1;
        s_nxt.trig_d = s_r.trig_s2;
        // Triggers are only ever followed, never generated here
        trig_ev = s_r.trig_s2 & ~s_r.trig_d;

        pop = s_r.head_v & out_ready;
        // Room counts the slot freed by a pop in the same cycle
        room = ~s_r.tail_v | pop;
        if (pop) begin
            s_nxt.head = s_r.tail;
            s_nxt.head_v = s_r.tail_v;
            s_nxt.tail_v = 1'b0;
        end

        if (s_r.st != vft_pkg::VFT_IDLE) begin
            s_nxt.stamp = s_r.stamp + `VFT_STAMP_W'(1);
        end

        // Clear first so a same-cycle loss still counts
        if (lost_clear) begin
            s_nxt.lost = `VFT_LOST_RST;
        end

        unique case (s_r.st)
            vft_pkg::VFT_IDLE: begin
                if (session_open) begin
                    s_nxt.st = vft_pkg::VFT_ARMED;
                    s_nxt.stamp = `VFT_STAMP_RST;
                    s_nxt.frame = `VFT_FRAME_RST;
                    s_nxt.held_v = 1'b0;
                end
            end
            vft_pkg::VFT_ARMED: begin
                if (trig_ev) begin
                    if (s_r.held_v && !room) begin
                        // Receiver stalled: the trigger is dropped as a lost frame
                        s_nxt.lost = s_nxt.lost + `VFT_LOST_W'(1);
                    end else begin
                        // Previous frame goes out only now
                        if (s_r.held_v) begin
                            push = 1'b1;
                            s_nxt.log_valid = 1'b1;
                            s_nxt.log_rec = s_r.held;
                        end
                        s_nxt.held_v = 1'b0;
                        s_nxt.cur.frame = s_r.frame;
                        s_nxt.cur.stamp = s_r.stamp;
                        s_nxt.frame = s_r.frame + `VFT_FRAME_W'(1);
                        s_nxt.cam_req = 1'b1;
                        s_nxt.st = vft_pkg::VFT_CAPTURE;
                    end
                end
            end
            vft_pkg::VFT_CAPTURE: begin
                if (trig_ev) begin
                    s_nxt.lost = s_nxt.lost + `VFT_LOST_W'(1);
                end
                if (cam_done) begin
                    s_nxt.file_append = 1'b1;
                    s_nxt.trk_start = 1'b1;
                    s_nxt.st = vft_pkg::VFT_TRACK;
                end
            end
            vft_pkg::VFT_TRACK: begin
                if (trig_ev) begin
                    s_nxt.lost = s_nxt.lost + `VFT_LOST_W'(1);
                end
                if (trk_done) begin
                    s_nxt.held = s_r.cur;
                    s_nxt.held.mask = trk_found & target_enable;
                    s_nxt.held.pos = pos_kept;
                    s_nxt.held_v = 1'b1;
                    s_nxt.st = vft_pkg::VFT_ARMED;
                end
            end
        endcase

        // Close wins over the pulses, the push and the state, but not a same-cycle lost count or pop; a record still held is discarded
        if (session_close && s_r.st != vft_pkg::VFT_IDLE) begin
            s_nxt.files_close = 1'b1;
            s_nxt.held_v = 1'b0;
            s_nxt.cam_req = 1'b0;
            s_nxt.file_append = 1'b0;
            s_nxt.trk_start = 1'b0;
            push = 1'b0;
            s_nxt.log_valid = 1'b0;
            s_nxt.st = vft_pkg::VFT_IDLE;
        end

        if (push) begin
            if (!s_nxt.head_v) begin
                s_nxt.head = push_rec;
                s_nxt.head_v = 1'b1;
            end else begin
                s_nxt.tail = push_rec;
                s_nxt.tail_v = 1'b1;
            end
        end

        // Session flag kept in a flop so the output is glitch free
        s_nxt.rec = (s_nxt.st != vft_pkg::VFT_IDLE);
    end

    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            s_r <= '0;
            s_r.st <= vft_pkg::VFT_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign out_valid = s_r.head_v;
    assign out_rec = s_r.head;
    assign cam_req = s_r.cam_req;
    assign file_append = s_r.file_append;
    assign trk_start = s_r.trk_start;
    assign files_close = s_r.files_close;
    assign log_valid = s_r.log_valid;
    assign log_rec = s_r.log_rec;
    assign recording = s_r.rec;
    assign lost_count = s_r.lost;

endmodule

`default_nettype wire

/* File: test/vft_link_props.sv */
// Port assertions for the frame trigger link
`timescale 1ns/1ps
`default_nettype none
`include "vft_regs.svh"
module vft_link_props (
    input wire logic core_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic trig_pin, // Trigger
    input wire logic cam_req, // Fetch
    input wire logic file_append, // Append
    input wire logic trk_start, // Track
    input wire logic log_valid, // Log
    input wire logic out_valid, // Valid
    input wire logic out_ready, // Ready
    input wire vft_pkg::vft_rec_type out_rec, // Record
    input wire logic session_close, // Close
    input wire logic recording, // Open
    input wire logic files_close, // Closed
    input wire logic lost_clear, // Clear
    input wire logic [`VFT_LOST_W-1:0] lost_count // Lost
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    cam_after_trig_a: assert property (cam_req |-> $past(trig_pin, 3) && !$past(trig_pin, 4))
        else $error("fetch not tied to trigger");
    append_track_a: assert property (file_append |-> trk_start && !cam_req)
        else $error("append without track");
    log_sent_a: assert property (log_valid |-> out_valid && cam_req)
        else $error("log not with send");
    hold_rec_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_rec))
        else $error("record dropped");
    close_pulse_a: assert property (session_close && recording |=> files_close && !recording)
        else $error("close ignored");
    idle_quiet_a: assert property (!recording |-> !cam_req && !log_valid)
        else $error("activity while idle");
    lost_clear_a: assert property (lost_clear |=> lost_count <= 16'h0001)
        else $error("lost count not cleared");
    lost_step_a: assert property (!lost_clear |=> lost_count - $past(lost_count) <= 16'h0001)
        else $error("lost count jump");
    pop_c: cover property (out_valid && out_ready);
    lost_c: cover property (lost_count != 16'h0000 ##1 lost_clear);
    close_c: cover property (files_close);
endmodule
`default_nettype wire

/* File: test/vft_ctrl_model.sv */
// Controller side: issues frame triggers and consumes records
`timescale 1ns/1ps
`default_nettype none
module vft_ctrl_model (
    input wire logic core_clk, // Clock
    input wire logic stall, // Hold off consumer
    output logic trig_pin, // Frame trigger
    output logic out_ready // Accept record
);
    int seed = 5;
    initial trig_pin = 1'h0;
    initial out_ready = 1'h0;
    always @(negedge core_clk) out_ready <= !stall && ($random(seed) % 2 != 0);
    // Sole source of trigger instants; caller paces them
    task automatic fire();
        trig_pin <= 1'h1;
        repeat (4) @(negedge core_clk);
        trig_pin <= 1'h0;
        repeat (2) @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

/* File: test/vft_link_tb_top.sv */
// Self-checking bench for the frame trigger link
`timescale 1ns/1ps
`default_nettype none
`include "vft_regs.svh"
module vft_link_tb_top;
    logic core_clk = 1'h0;
    logic nrst = 1'h0;
    logic session_open = 1'h0;
    logic session_close = 1'h0;
    logic lost_clear = 1'h0;
    logic cam_done = 1'h0;
    logic trk_done = 1'h0;
    logic stall = 1'h0;
    logic [`VFT_TARGETS-1:0] target_enable = 8'hFF;
    logic [`VFT_TARGETS-1:0] trk_found = 8'h00;
    vft_pkg::vft_pos_set_type trk_pos = '0;
    logic trig_pin, out_ready, out_valid, cam_req, file_append, trk_start;
    logic files_close, log_valid, recording;
    logic [`VFT_LOST_W-1:0] lost_count;
    vft_pkg::vft_rec_type out_rec, log_rec, e;
    vft_pkg::vft_rec_type exp_q[$], log_q[$];
    int n_fail = 0, checks_done = 0, seed = 5, cyc = 0, fr = 0, cs, open_cyc = 0;
    vft_link vft_link_i (.*);
    vft_ctrl_model vft_ctrl_model_i (.*);
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    task automatic chk(input string what, input vft_pkg::vft_rec_type seen, want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic await(ref logic s, input string what);
        int k = 0;
        while (s !== 1'h1 && k < 8) begin
            @(negedge core_clk);
            k++;
        end
        cs = cyc;
        chk(what, k < 8, 1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge core_clk);
        s = 1'h0;
    endtask
    task automatic drain();
        for (int k = 0; k < 40 && out_valid; k++) @(negedge core_clk);
        chk("drained", out_valid, 0);
    endtask
    function automatic vft_pkg::vft_rec_type exp_rec(input int f, input int t);
        exp_rec = '0;
        exp_rec.frame = f[`VFT_FRAME_W-1:0];
        exp_rec.stamp = t;
        exp_rec.mask = trk_found & target_enable;
        for (int i = 0; i < `VFT_TARGETS; i++)
            if (exp_rec.mask[i]) exp_rec.pos[i] = trk_pos[i];
    endfunction
    // Mode 0 plain, 1 extra trigger while busy, 2 trigger refused on full buffer
    task automatic frame(input int mode);
        logic [`VFT_LOST_W-1:0] lc;
        int t;
        lc = lost_count;
        if (mode == 2) begin
            vft_ctrl_model_i.fire();
            chk("lost_full", lost_count, lc + 1'h1);
            return;
        end
        fork
            vft_ctrl_model_i.fire();
            await(cam_req, "cam_req");
        join
        // Stamp is taken the cycle before the capture request shows
        t = cs - 1 - open_cyc;
        if (mode == 1) begin
            vft_ctrl_model_i.fire();
            chk("lost_busy", lost_count, lc + 1'h1);
        end
        repeat ($random(seed) & 3) @(negedge core_clk);
        pulse(cam_done);
        await(file_append, "file_append");
        trk_found = $random(seed);
        for (int i = 0; i < `VFT_TARGETS; i++) trk_pos[i] = trk_found[i] ? $random(seed) : 0;
        repeat ($random(seed) & 3) @(negedge core_clk);
        pulse(trk_done);
        exp_q.push_back(exp_rec(fr, t));
        log_q.push_back(exp_rec(fr, t));
        fr++;
    endtask
    // Stamps count cycles from the edge that opened the session
    always @(posedge core_clk) begin
        if (nrst && log_valid) begin
            e = log_q.size() ? log_q.pop_front() : '1;
            chk("log_rec", log_rec, e);
        end
        if (nrst && out_valid && out_ready) begin
            e = exp_q.size() ? exp_q.pop_front() : '1;
            chk("arrival", cyc - open_cyc > e.stamp, 1);
            chk("out_rec", out_rec, e);
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(negedge core_clk);
        nrst = 1'h1;
        repeat (4) @(negedge core_clk);
        for (int s = 0; s < 2; s++) begin
            target_enable = $random(seed);
            exp_q.delete();
            log_q.delete();
            fr = 0;
            pulse(session_open);
            open_cyc = cyc;
            chk("recording", recording, 1);
            for (int i = 0; i < 10; i++) frame(i == 4);
            pulse(session_open);
            drain();
            stall <= 1'h1;
            frame(0);
            frame(0);
            frame(2);
            stall <= 1'h0;
            drain();
            frame(0);
            pulse(lost_clear);
            chk("lost_clear", lost_count, 0);
            // Sent records must leave before the queues are reset for the next session
            drain();
            pulse(session_close);
            await(files_close, "files_close");
            chk("closed", recording, 0);
        end
        tally_and_finish();
    end
endmodule
bind vft_link vft_link_props vft_link_props_i (.*);
`default_nettype wire
